// File: design/lcsm_defs.vh
`ifndef LCSM_DEFS_VH
`define LCSM_DEFS_VH
// ==========================================================
// Register byte offsets
`define LCSM_OFF_CTRL 12'h000
`define LCSM_OFF_TIME 12'h004
`define LCSM_OFF_WDOG 12'h008
`define LCSM_OFF_STAT 12'h00c
`define LCSM_OFF_INFO 12'h010
// ==========================================================
// Control register fields
`define LCSM_CTRL_CHG_EN 0
`define LCSM_CTRL_TRICKLE_EN 1
`define LCSM_CTRL_SKIP_DIS 2
`define LCSM_CTRL_WDOG_EN 3
`define LCSM_CTRL_RESET 32'h0000_0002
// ==========================================================
// Time register fields: fast-charge and top-off limits in ticks
`define LCSM_TIME_RESET 32'h0010_0040
// ==========================================================
// Watchdog clear value
`define LCSM_WDOG_CLEAR 8'h01
// ==========================================================
// State codes
`define LCSM_ST_OFF 4'h0
`define LCSM_ST_PRE 4'h1
`define LCSM_ST_TRK 4'h2
`define LCSM_ST_FCC 4'h3
`define LCSM_ST_FCV 4'h4
`define LCSM_ST_TOP 4'h5
`define LCSM_ST_DONE 4'h6
`define LCSM_ST_TFLT 4'h7
`define LCSM_ST_WDS 4'h8
// ==========================================================
// Detail codes
`define LCSM_DTL_PRE 8'h00
`define LCSM_DTL_FCC 8'h01
`define LCSM_DTL_FCV 8'h02
`define LCSM_DTL_TOP 8'h03
`define LCSM_DTL_DONE 8'h04
`define LCSM_DTL_TFLT 8'h06
`define LCSM_DTL_WDS 8'h0b
`define LCSM_DTL_OFF 8'h08
// ==========================================================
// Timing: one timer tick per millisecond at 100 MHz
`define LCSM_CLK_HZ 100000000
`define LCSM_TICK_MS 1
`define LCSM_TICK_CYC (`LCSM_CLK_HZ / 1000 * `LCSM_TICK_MS)
`define LCSM_REPORT_MS 30
`define LCSM_TERM_MS 30
`define LCSM_PREQUAL_MS 1800000
`define LCSM_WDOG_MS 80000
`endif

// File: design/lcsm_tick.v
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Divider giving a one-cycle enable every PERIOD clocks
module lcsm_tick #(
	parameter PERIOD = 100000
) (
	// Clock and reset
	input wire clk,
	input wire rst,
	// Enable out
	output reg tick
);
	reg [31:0] cnt_reg;

	// Free-running count with wrap
	always @(posedge clk) begin
		if (rst) begin
			cnt_reg <= 32'h0;
			tick <= 1'b0;
		end else if (cnt_reg >= PERIOD - 1) begin
			cnt_reg <= 32'h0;
			tick <= 1'b1;
		end else begin
			cnt_reg <= cnt_reg + 32'h1;
			tick <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// File: design/lcsm_timer.v
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Residence timer: counts ticks while run, clears otherwise
module lcsm_timer (
	// Clock and reset
	input wire clk,
	input wire rst,
	// Control
	input wire run,
	input wire tick,
	input wire [31:0] limit,
	// Result
	output wire expired
);
	reg [31:0] cnt_reg;

	// Count only while supervised, saturating at the limit
	always @(posedge clk) begin
		if (rst || !run)
			cnt_reg <= 32'h0;
		else if (tick && cnt_reg < limit)
			cnt_reg <= cnt_reg + 32'h1;
	end

	assign expired = run && (cnt_reg >= limit);
endmodule
`default_nettype wire

// File: design/lcsm_charger.v
`timescale 1ns/10ps
`default_nettype none
`include "lcsm_defs.vh"
module lcsm_charger #(
	parameter PREQUAL_MS = `LCSM_PREQUAL_MS,
	parameter WDOG_MS = `LCSM_WDOG_MS,
	parameter TICK_CYC = `LCSM_TICK_CYC
) (
	// Clock and reset
	input wire REF_CLK,
	input wire SYS_RST,
	// APB slave
	input wire PSEL,
	input wire PENABLE,
	input wire PWRITE,
	input wire [11:0] PADDR,
	input wire [31:0] PWDATA,
	output wire [31:0] PRDATA,
	output wire PREADY,
	output wire PSLVERR,
	// Comparator inputs
	input wire ABOVE_PRECHARGE,
	input wire ABOVE_TRICKLE,
	input wire AT_REGULATION,
	input wire BELOW_RESTART,
	input wire BELOW_TOPOFF_CURRENT,
	input wire DIE_OVER_TREG,
	input wire INPUT_LIMITED,
	input wire INPUT_VOLTAGE_LOW,
	input wire INPUT_PRESENT,
	// Power stage controls
	output reg CHARGE_ON,
	output reg [1:0] CURRENT_SEL,
	output reg CURRENT_FOLDBACK,
	output reg VOLTAGE_REG_ON,
	output reg SKIP_MODE_ON,
	// Status
	output reg CHARGER_GOOD_STATUS,
	output reg [7:0] CHARGER_DETAIL_CODE,
	output reg CHARGER_EVENT_FLAG
);
	// ==========================================================
	// Current selections
	localparam [1:0] CUR_ZERO = 2'h0;
	localparam [1:0] CUR_PRE = 2'h1;
	localparam [1:0] CUR_TRK = 2'h2;
	localparam [1:0] CUR_FAST = 2'h3;
	localparam [31:0] REPORT_TICKS = `LCSM_REPORT_MS / `LCSM_TICK_MS;
	localparam [31:0] TERM_TICKS = `LCSM_TERM_MS / `LCSM_TICK_MS;
	localparam [31:0] PREQUAL_TICKS = PREQUAL_MS / `LCSM_TICK_MS;
	localparam [31:0] WDOG_TICKS = WDOG_MS / `LCSM_TICK_MS;

	reg [31:0] ctrl_reg;
	reg [31:0] time_reg;
	reg [3:0] state_reg;
	reg [3:0] state_next;
	reg [31:0] wdog_cnt_reg;
	reg wdog_exp_reg;
	reg input_prev_reg;
	reg chg_en_prev_reg;
	reg [31:0] prdata_reg;
	wire tick;
	wire report_done;
	wire term_done;
	wire prequal_exp;
	wire fast_exp;
	wire topoff_exp;
	wire wr;
	wire rd;
	wire chg_en;
	wire trickle_en;
	wire restart;
	wire in_charging;

	// ==========================================================
	// APB access: zero wait states, unmapped reads zero, no error
	assign wr = PSEL && PENABLE && PWRITE;
	assign rd = PSEL && !PWRITE;
	assign PREADY = 1'b1;
	assign PSLVERR = 1'b0;
	assign PRDATA = prdata_reg;
	assign chg_en = ctrl_reg[`LCSM_CTRL_CHG_EN];
	assign trickle_en = ctrl_reg[`LCSM_CTRL_TRICKLE_EN];

	// Writable control and time registers
	always @(posedge REF_CLK) begin
		if (SYS_RST) begin
			ctrl_reg <= `LCSM_CTRL_RESET;
			time_reg <= `LCSM_TIME_RESET;
		end else if (wr) begin
			if (PADDR == `LCSM_OFF_CTRL)
				ctrl_reg <= {28'h0, PWDATA[3:0]};
			if (PADDR == `LCSM_OFF_TIME)
				time_reg <= PWDATA;
		end
	end

	// Read data captured in setup cycle, valid in access phase
	always @(posedge REF_CLK) begin
		if (SYS_RST) begin
			prdata_reg <= 32'h0;
		end else if (rd && !PENABLE) begin
			case (PADDR)
				`LCSM_OFF_CTRL: prdata_reg <= ctrl_reg;
				`LCSM_OFF_TIME: prdata_reg <= time_reg;
				`LCSM_OFF_STAT: prdata_reg <= {15'h0, CHARGER_EVENT_FLAG, CHARGER_DETAIL_CODE,
					3'h0, CHARGER_GOOD_STATUS, state_reg};
				`LCSM_OFF_INFO: prdata_reg <= {31'h0, wdog_exp_reg};
				default: prdata_reg <= 32'h0;
			endcase
		end
	end

	// ==========================================================
	// Millisecond timebase
	lcsm_tick #(
		.PERIOD(TICK_CYC)
	) u_tick (
		.clk(REF_CLK),
		.rst(SYS_RST),
		.tick(tick)
	);

	// ==========================================================
	// Watchdog: host writes clear value within each period
	always @(posedge REF_CLK) begin
		if (SYS_RST || !ctrl_reg[`LCSM_CTRL_WDOG_EN]) begin
			wdog_cnt_reg <= 32'h0;
			wdog_exp_reg <= 1'b0;
		end else if (wr && PADDR == `LCSM_OFF_WDOG && PWDATA[7:0] == `LCSM_WDOG_CLEAR) begin
			wdog_cnt_reg <= 32'h0;
			wdog_exp_reg <= 1'b0;
		end else if (tick) begin
			if (wdog_cnt_reg >= WDOG_TICKS - 32'h1)
				wdog_exp_reg <= 1'b1;
			else
				wdog_cnt_reg <= wdog_cnt_reg + 32'h1;
		end
	end

	// Restart after fault: charge off then on, or input reinserted
	always @(posedge REF_CLK) begin
		if (SYS_RST) begin
			input_prev_reg <= 1'b1; // Idle present: no false insertion after reset
			chg_en_prev_reg <= 1'b0;
		end else begin
			input_prev_reg <= INPUT_PRESENT;
			chg_en_prev_reg <= chg_en;
		end
	end
	assign restart = (INPUT_PRESENT && !input_prev_reg) || (chg_en && !chg_en_prev_reg);

	// ==========================================================
	// Residence timers, cleared on leaving supervised states
	lcsm_timer u_report (
		.clk(REF_CLK),
		.rst(SYS_RST || state_next != state_reg),
		.run(1'b1),
		.tick(tick),
		.limit(REPORT_TICKS),
		.expired(report_done)
	);
	lcsm_timer u_term (
		.clk(REF_CLK),
		.rst(SYS_RST),
		.run(state_reg == `LCSM_ST_FCV && BELOW_TOPOFF_CURRENT),
		.tick(tick),
		.limit(TERM_TICKS),
		.expired(term_done)
	);
	lcsm_timer u_prequal (
		.clk(REF_CLK),
		.rst(SYS_RST),
		.run(state_reg == `LCSM_ST_PRE || state_reg == `LCSM_ST_TRK),
		.tick(tick),
		.limit(PREQUAL_TICKS),
		.expired(prequal_exp)
	);
	lcsm_timer u_fast (
		.clk(REF_CLK),
		.rst(SYS_RST),
		.run(state_reg == `LCSM_ST_FCC || state_reg == `LCSM_ST_FCV),
		.tick(tick),
		.limit({16'h0, time_reg[31:16]}),
		.expired(fast_exp)
	);
	lcsm_timer u_topoff (
		.clk(REF_CLK),
		.rst(SYS_RST),
		.run(state_reg == `LCSM_ST_TOP),
		.tick(tick),
		.limit({16'h0, time_reg[15:0]}),
		.expired(topoff_exp)
	);

	// ==========================================================
	// Next-state logic
	assign in_charging = state_reg == `LCSM_ST_PRE || state_reg == `LCSM_ST_TRK ||
		state_reg == `LCSM_ST_FCC || state_reg == `LCSM_ST_FCV ||
		state_reg == `LCSM_ST_TOP || state_reg == `LCSM_ST_DONE;
	always @* begin
		state_next = state_reg;
		if (!chg_en && state_reg != `LCSM_ST_TFLT) begin
			state_next = `LCSM_ST_OFF;
		end else if (wdog_exp_reg && in_charging) begin
			state_next = `LCSM_ST_WDS;
		end else begin
			case (state_reg)
				`LCSM_ST_OFF, `LCSM_ST_WDS: begin
					if (chg_en && !wdog_exp_reg)
						state_next = `LCSM_ST_PRE;
				end
				`LCSM_ST_PRE: begin
					if (prequal_exp)
						state_next = `LCSM_ST_TFLT;
					else if (ABOVE_PRECHARGE)
						state_next = `LCSM_ST_TRK;
				end
				`LCSM_ST_TRK: begin
					if (prequal_exp)
						state_next = `LCSM_ST_TFLT;
					else if (!ABOVE_PRECHARGE)
						state_next = `LCSM_ST_PRE;
					else if (ABOVE_TRICKLE || !trickle_en)
						state_next = `LCSM_ST_FCC;
				end
				`LCSM_ST_FCC: begin
					if (fast_exp)
						state_next = `LCSM_ST_TFLT;
					else if (AT_REGULATION)
						state_next = `LCSM_ST_FCV;
				end
				`LCSM_ST_FCV: begin
					if (fast_exp)
						state_next = `LCSM_ST_TFLT;
					else if (term_done)
						state_next = `LCSM_ST_TOP;
				end
				`LCSM_ST_TOP: begin
					if (BELOW_RESTART)
						state_next = `LCSM_ST_FCC;
					else if (topoff_exp)
						state_next = `LCSM_ST_DONE;
				end
				`LCSM_ST_DONE: begin
					if (BELOW_RESTART)
						state_next = `LCSM_ST_FCC;
				end
				`LCSM_ST_TFLT: begin
					if (restart && chg_en)
						state_next = `LCSM_ST_PRE;
				end
				default: state_next = `LCSM_ST_OFF;
			endcase
		end
	end

	// State register
	always @(posedge REF_CLK) begin
		if (SYS_RST)
			state_reg <= `LCSM_ST_OFF;
		else
			state_reg <= state_next;
	end

	// ==========================================================
	// Power stage controls per state
	always @(posedge REF_CLK) begin
		if (SYS_RST) begin
			CHARGE_ON <= 1'b0;
			CURRENT_SEL <= CUR_ZERO;
			CURRENT_FOLDBACK <= 1'b0;
			VOLTAGE_REG_ON <= 1'b0;
			SKIP_MODE_ON <= 1'b0;
		end else begin
			CHARGE_ON <= state_reg >= `LCSM_ST_PRE && state_reg <= `LCSM_ST_TOP;
			VOLTAGE_REG_ON <= state_reg == `LCSM_ST_FCV || state_reg == `LCSM_ST_TOP;
			SKIP_MODE_ON <= !ctrl_reg[`LCSM_CTRL_SKIP_DIS];
			CURRENT_FOLDBACK <= DIE_OVER_TREG || INPUT_LIMITED || INPUT_VOLTAGE_LOW;
			case (state_reg)
				`LCSM_ST_PRE: CURRENT_SEL <= CUR_PRE;
				`LCSM_ST_TRK: CURRENT_SEL <= trickle_en ? CUR_TRK : CUR_FAST;
				`LCSM_ST_FCC, `LCSM_ST_FCV, `LCSM_ST_TOP: CURRENT_SEL <= CUR_FAST;
				default: CURRENT_SEL <= CUR_ZERO;
			endcase
		end
	end

	// ==========================================================
	// Status reporting after settling; timer fault reports at once
	always @(posedge REF_CLK) begin
		if (SYS_RST) begin
			CHARGER_GOOD_STATUS <= 1'b0;
			CHARGER_DETAIL_CODE <= `LCSM_DTL_OFF;
			CHARGER_EVENT_FLAG <= 1'b0;
		end else begin
			CHARGER_EVENT_FLAG <= 1'b0;
			if (state_next == `LCSM_ST_TFLT && state_reg != `LCSM_ST_TFLT) begin
				CHARGER_EVENT_FLAG <= 1'b1;
				CHARGER_GOOD_STATUS <= 1'b0;
				CHARGER_DETAIL_CODE <= `LCSM_DTL_TFLT;
			end else if (report_done && state_next == state_reg) begin
				case (state_reg)
					`LCSM_ST_PRE, `LCSM_ST_TRK, `LCSM_ST_FCC, `LCSM_ST_FCV, `LCSM_ST_TOP: begin
						CHARGER_EVENT_FLAG <= !CHARGER_GOOD_STATUS;
						CHARGER_GOOD_STATUS <= 1'b1;
						case (state_reg)
							`LCSM_ST_FCC: CHARGER_DETAIL_CODE <= `LCSM_DTL_FCC;
							`LCSM_ST_FCV: CHARGER_DETAIL_CODE <= `LCSM_DTL_FCV;
							`LCSM_ST_TOP: CHARGER_DETAIL_CODE <= `LCSM_DTL_TOP;
							default: CHARGER_DETAIL_CODE <= `LCSM_DTL_PRE;
						endcase
					end
					`LCSM_ST_DONE: begin
						CHARGER_EVENT_FLAG <= !CHARGER_GOOD_STATUS && CHARGER_DETAIL_CODE != `LCSM_DTL_DONE;
						CHARGER_GOOD_STATUS <= 1'b0;
						CHARGER_DETAIL_CODE <= `LCSM_DTL_DONE;
					end
					`LCSM_ST_WDS: begin
						CHARGER_EVENT_FLAG <= CHARGER_GOOD_STATUS;
						CHARGER_GOOD_STATUS <= 1'b0;
						CHARGER_DETAIL_CODE <= `LCSM_DTL_WDS;
					end
					`LCSM_ST_OFF: begin
						CHARGER_GOOD_STATUS <= 1'b0;
						CHARGER_DETAIL_CODE <= `LCSM_DTL_OFF;
					end
					default: CHARGER_GOOD_STATUS <= CHARGER_GOOD_STATUS;
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// File: sim/lcsm_charger_monitor.sv
`timescale 1ns/10ps
`default_nettype none
// ==========
// Port checker for the charge sequencer
module lcsm_charger_monitor #(
	parameter PREQUAL_MS = 1,
	parameter WDOG_MS = 1,
	parameter int TICK_CYC = 100000
) (
	// Clock and reset
	input wire logic REF_CLK,
	input wire logic SYS_RST,
	// Comparators and limits
	input wire logic ABOVE_PRECHARGE,
	input wire logic ABOVE_TRICKLE,
	input wire logic AT_REGULATION,
	input wire logic DIE_OVER_TREG,
	input wire logic INPUT_LIMITED,
	input wire logic INPUT_VOLTAGE_LOW,
	// Power stage and status
	input wire logic CHARGE_ON,
	input wire logic [1:0] CURRENT_SEL,
	input wire logic CURRENT_FOLDBACK,
	input wire logic VOLTAGE_REG_ON,
	input wire logic CHARGER_GOOD_STATUS,
	input wire logic [7:0] CHARGER_DETAIL_CODE,
	input wire logic CHARGER_EVENT_FLAG
);
	default clocking @(posedge REF_CLK);
	endclocking
	default disable iff (SYS_RST);
	localparam int REPORT_MIN = 28 * TICK_CYC;
	logic [21:0] hold_cnt;
	// Cycles since CHARGE_ON, CURRENT_SEL or VOLTAGE_REG_ON last moved, saturating
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST || $changed({CHARGE_ON, CURRENT_SEL, VOLTAGE_REG_ON}))
			hold_cnt <= 22'h0;
		else if (hold_cnt != 22'h3fffff)
			hold_cnt <= hold_cnt + 22'h1;
	end
	AST_PRE_HOLD: assert property (CHARGE_ON && CURRENT_SEL == 2'h1 && !ABOVE_PRECHARGE ##1 !ABOVE_PRECHARGE
		|=> CURRENT_SEL inside {2'h0, 2'h1}) else $error("precharge left with a low cell");
	AST_PRE_EXIT: assert property (CHARGE_ON && CURRENT_SEL == 2'h1 ##1 ABOVE_PRECHARGE [*2]
		|=> CURRENT_SEL != 2'h1) else $error("precharge kept above threshold");
	AST_TRK_EXIT: assert property (CURRENT_SEL == 2'h2 ##1 ABOVE_TRICKLE [*2]
		|=> CURRENT_SEL != 2'h2) else $error("trickle kept above threshold");
	AST_CC_TO_CV: assert property (CHARGE_ON && CURRENT_SEL == 2'h3 && !VOLTAGE_REG_ON ##1 AT_REGULATION [*2]
		|=> VOLTAGE_REG_ON || !CHARGE_ON) else $error("no voltage regulation at target");
	AST_CV_ENTRY: assert property ($rose(VOLTAGE_REG_ON)
		|-> $past(CHARGE_ON) && $past(CURRENT_SEL) == 2'h3) else $error("regulation entered not from fast charge");
	AST_FOLDBACK: assert property (DIE_OVER_TREG || INPUT_LIMITED || INPUT_VOLTAGE_LOW
		|=> CURRENT_FOLDBACK) else $error("current not folded back");
	AST_FAULT: assert property ($rose(CHARGER_DETAIL_CODE == 8'h06)
		|-> !CHARGER_GOOD_STATUS && CHARGER_EVENT_FLAG ##1 !CHARGE_ON)
		else $error("timer fault reported badly");
	AST_EVT_PULSE: assert property (CHARGER_EVENT_FLAG |=> !CHARGER_EVENT_FLAG)
		else $error("event longer than one cycle");
	AST_REPORT_WAIT: assert property ($rose(CHARGER_GOOD_STATUS) |-> hold_cnt >= REPORT_MIN)
		else $error("status updated before report delay");
	AST_IDLE_ZERO: assert property (!CHARGE_ON |-> CURRENT_SEL == 2'h0 && !VOLTAGE_REG_ON)
		else $error("current selected while not charging");
	COV_CV: cover property ($rose(VOLTAGE_REG_ON));
	COV_FAULT: cover property ($rose(CHARGER_DETAIL_CODE == 8'h06));
	COV_FOLD: cover property ($rose(CURRENT_FOLDBACK));
endmodule
bind lcsm_charger lcsm_charger_monitor #(.PREQUAL_MS(PREQUAL_MS), .WDOG_MS(WDOG_MS), .TICK_CYC(TICK_CYC))
	u_lcsm_charger_monitor (
	.REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .ABOVE_PRECHARGE(ABOVE_PRECHARGE), .ABOVE_TRICKLE(ABOVE_TRICKLE),
	.AT_REGULATION(AT_REGULATION), .DIE_OVER_TREG(DIE_OVER_TREG), .INPUT_LIMITED(INPUT_LIMITED),
	.INPUT_VOLTAGE_LOW(INPUT_VOLTAGE_LOW), .CHARGE_ON(CHARGE_ON), .CURRENT_SEL(CURRENT_SEL),
	.CURRENT_FOLDBACK(CURRENT_FOLDBACK), .VOLTAGE_REG_ON(VOLTAGE_REG_ON), .CHARGER_GOOD_STATUS(CHARGER_GOOD_STATUS),
	.CHARGER_DETAIL_CODE(CHARGER_DETAIL_CODE), .CHARGER_EVENT_FLAG(CHARGER_EVENT_FLAG));
`default_nettype wire

// File: sim/lcsm_cell.sv
`timescale 1ns/10ps
`default_nettype none
// ==========
// Cell and sense front end seen by the charger
module lcsm_cell #(
	parameter int PRE_MV = 3000,
	parameter int TRK_MV = 3300,
	parameter int REG_MV = 4200,
	parameter int HYS_MV = 100
) (
	// Clock and cell state
	input wire logic clk,
	input wire logic [12:0] mv,
	input wire logic low_i,
	// Comparator levels
	output logic above_pre,
	output logic above_trk,
	output logic at_reg,
	output logic below_rst,
	output logic below_to
);
	// Comparators settle one cycle after the cell moves
	always_ff @(posedge clk) begin
		above_pre <= mv > PRE_MV; // a dead pack reads low
		above_trk <= mv > TRK_MV;
		at_reg <= mv >= REG_MV;
		below_rst <= mv < REG_MV - HYS_MV;
		below_to <= low_i;
	end
endmodule
`default_nettype wire

// File: sim/tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "lcsm_defs.vh"
// ==========
// Charge sequencer bench
module tb;
	logic clk, rst, psel, pen, pwr, die, ilim, vlow, low, sk, inp;
	logic [11:0] padr;
	logic [31:0] pwd, t;
	logic [12:0] mv;
	wire logic rdy, err, ap, at, ar, br, bt, con, fb, vr, skon, good, evt;
	wire logic [1:0] sel;
	wire logic [7:0] dtl;
	wire logic [31:0] prd;
	int mismatches, cmp_count, n;
	logic [31:0] exp_q[$];
	// Sequencer with a short tick and a prequal limit below the report delay
	lcsm_charger #(.PREQUAL_MS(20), .WDOG_MS(2), .TICK_CYC(200)) u_lcsm_charger (.REF_CLK(clk), .SYS_RST(rst),
		.PSEL(psel),
		.PENABLE(pen), .PWRITE(pwr), .PADDR(padr), .PWDATA(pwd), .PRDATA(prd), .PREADY(rdy), .PSLVERR(err),
		.ABOVE_PRECHARGE(ap), .ABOVE_TRICKLE(at), .AT_REGULATION(ar), .BELOW_RESTART(br),
		.BELOW_TOPOFF_CURRENT(bt), .DIE_OVER_TREG(die), .INPUT_LIMITED(ilim), .INPUT_VOLTAGE_LOW(vlow),
		.INPUT_PRESENT(inp), .CHARGE_ON(con), .CURRENT_SEL(sel), .CURRENT_FOLDBACK(fb),
		.VOLTAGE_REG_ON(vr), .SKIP_MODE_ON(skon), .CHARGER_GOOD_STATUS(good),
		.CHARGER_DETAIL_CODE(dtl), .CHARGER_EVENT_FLAG(evt));
	// Cell model
	lcsm_cell u_lcsm_cell (.clk(clk), .mv(mv), .low_i(low), .above_pre(ap), .above_trk(at),
		.at_reg(ar), .below_rst(br), .below_to(bt));
	// ==========
	// Helpers
	function automatic logic [31:0] outs();
		return {16'h0, dtl, 3'h0, con, sel, vr, good};
	endfunction
	function automatic logic [31:0] st(input logic [3:0] s, input logic [7:0] d);
		return {16'h0, d, 4'h0, s};
	endfunction
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			mismatches++;
			$display("unexpected at %0t: got %h, want %h", $time, g, e);
		end
	endtask
	task automatic summarize;
		if (mismatches == 0 && cmp_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic settle;
		repeat (5) @(posedge clk);
	endtask
	// One bus transfer; a read notes its expected word
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		k = 0;
		psel <= 1'b1;
		pwr <= w;
		padr <= a;
		pwd <= w ? d : 32'h0;
		if (!w) exp_q.push_back(d);
		@(posedge clk);
		pen <= 1'b1;
		do begin
			@(posedge clk);
			k++;
		end while (rdy !== 1'b1 && k < 20);
		if (k == 20) mismatches++;
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge clk);
	endtask
	// Compare each completed read with the oldest note
	always @(posedge clk) begin
		if (psel && pen && rdy === 1'b1 && !pwr) chk(prd, exp_q.pop_front());
	end
	// Clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Hang guard
	initial begin
		repeat (60000) @(posedge clk);
		mismatches++;
		summarize();
	end
	// ==========
	// Main sequence
	initial begin
		mismatches = 0;
		cmp_count = 0;
		{rst, psel, pen, pwr, die, ilim, vlow, low, sk} = 9'h100;
		inp = 1'b1;
		{padr, pwd, mv} = 57'h0;
		void'($urandom(32'hebd0c115));
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		chk(outs(), 32'h0000_0800);
		apb(1'b0, `LCSM_OFF_CTRL, `LCSM_CTRL_RESET);
		apb(1'b0, `LCSM_OFF_TIME, `LCSM_TIME_RESET);
		apb(1'b0, `LCSM_OFF_WDOG, 32'h0);
		apb(1'b0, 12'h014, 32'h0);
		apb(1'b0, `LCSM_OFF_STAT, st(`LCSM_ST_OFF, `LCSM_DTL_OFF));
		t = ($urandom & 32'h00ff_000f) | 32'h0100_0010;
		apb(1'b1, `LCSM_OFF_TIME, t);
		apb(1'b0, `LCSM_OFF_TIME, t);
		sk = 1'($urandom_range(1, 0));
		apb(1'b1, `LCSM_OFF_CTRL, {29'h0, sk, 2'b11});
		settle();
		chk({31'h0, skon}, {31'h0, ~sk});
		chk(outs(), 32'h0000_0814);
		apb(1'b0, `LCSM_OFF_STAT, st(`LCSM_ST_PRE, `LCSM_DTL_OFF));
		mv <= 13'($urandom_range(3299, 3001));
		settle();
		chk(outs(), 32'h0000_0818);
		apb(1'b1, `LCSM_OFF_CTRL, {29'h0, sk, 2'b01});
		settle();
		chk(outs(), 32'h0000_081c);
		for (n = 0; n < 3; n++) begin
			{die, ilim, vlow} <= 3'h1 << n;
			settle();
			chk({31'h0, fb}, 32'h1);
			{die, ilim, vlow} <= 3'h0;
			settle();
		end
		mv <= 13'h1068;
		settle();
		low <= 1'b1;
		repeat (1000) @(posedge clk);
		chk({30'h0, vr, con}, 32'h3);
		apb(1'b0, `LCSM_OFF_STAT, st(`LCSM_ST_FCV, `LCSM_DTL_OFF));
		apb(1'b1, `LCSM_OFF_WDOG, {24'h0, `LCSM_WDOG_CLEAR});
		apb(1'b1, `LCSM_OFF_CTRL, 32'h0);
		{mv, low} <= 14'h0;
		settle();
		chk(outs(), 32'h0000_0800);
		apb(1'b1, `LCSM_OFF_CTRL, 32'h1);
		n = 0;
		while (evt !== 1'b1 && n < 20000) begin
			@(negedge clk);
			n++;
		end
		chk({31'h0, evt}, 32'h1);
		@(posedge clk);
		settle();
		chk(outs(), 32'h0000_0600);
		apb(1'b0, `LCSM_OFF_STAT, st(`LCSM_ST_TFLT, `LCSM_DTL_TFLT));
		apb(1'b1, `LCSM_OFF_CTRL, 32'h0);
		settle();
		chk(outs(), 32'h0000_0600);
		apb(1'b1, `LCSM_OFF_CTRL, 32'h1);
		settle();
		chk(outs(), 32'h0000_0614);
		// Full charge to done: report in constant voltage, then top-off and done
		mv <= 13'h1068;
		n = 0;
		while (evt !== 1'b1 && n < 20000) begin
			@(negedge clk);
			n++;
		end
		chk(outs(), 32'h0000_021f);
		@(posedge clk);
		low <= 1'b1;
		n = 0;
		while (dtl !== `LCSM_DTL_DONE && n < 40000) begin
			@(negedge clk);
			n++;
		end
		chk(outs(), 32'h0000_0400);
		summarize();
	end
endmodule
`default_nettype wire
